// ==== lcdft_defs.svh ====
`ifndef LCDFT_DEFS_SVH
`define LCDFT_DEFS_SVH

// Register map, one byte-wide register per aligned word
`define LCDFT_ADDR_CMD 8'h00
`define LCDFT_ADDR_PARAM 8'h04
`define LCDFT_ADDR_BPL 8'h08
`define LCDFT_ADDR_LLEN 8'h0c
`define LCDFT_ADDR_LPF 8'h10
`define LCDFT_ADDR_PITCHL 8'h14
`define LCDFT_ADDR_PITCHH 8'h18
`define LCDFT_ADDR_CONFIG 8'h1c
`define LCDFT_ADDR_STATUS 8'h20

// Command codes
`define LCDFT_CMD_SYSSET 8'h01
`define LCDFT_CMD_SLEEP 8'h02
`define LCDFT_CMD_DISPLAY_EN 8'h03

// Parameter positions after the system-configuration command
`define LCDFT_PIDX_NONE 4'd0
`define LCDFT_PIDX_CONFIG 4'd1
`define LCDFT_PIDX_BPL 4'd4
`define LCDFT_PIDX_LLEN 4'd5
`define LCDFT_PIDX_LPF 4'd6
`define LCDFT_PIDX_PITCHL 4'd7
`define LCDFT_PIDX_PITCHH 4'd8

// Field positions and limits
`define LCDFT_PANEL_BIT 3
`define LCDFT_BPL_MAX 8'hef

// Reset values
`define LCDFT_RST_CONFIG 8'h00
`define LCDFT_RST_BPL 8'h27
`define LCDFT_RST_LLEN 8'h2f
`define LCDFT_RST_LPF 8'h3f
`define LCDFT_RST_PITCH 16'h0028

// Clock cycles per byte period
`define LCDFT_BYTE_DIV 4'h4

`endif

// ==== lcdft_pkg.sv ====
`default_nettype none

package lcdft_pkg;

   typedef enum logic [3:0] {
      ST_RUN = 4'b0001,
      ST_DRAIN = 4'b0010,
      ST_BLANKFRAME = 4'b0100,
      ST_SLEEP = 4'b1000
   } lcdft_mode_e;

   typedef struct packed {
      logic [3:0] div;
      logic [7:0] pos;
      logic [7:0] line;
      logic [15:0] lineBase;
      logic [15:0] addr;
      logic inDisp;
      logic lineStart;
      logic frameStart;
   } lcdft_ras_s;

   typedef struct packed {
      lcdft_mode_e mode;
      logic [7:0] cfgByte;
      logic [7:0] bpl;
      logic [7:0] llen;
      logic [7:0] lpf;
      logic [15:0] pitch;
      logic [3:0] pidx;
      logic [7:0] rdData;
      logic busOe;
      logic [15:0] memAddr;
      logic memRdN;
      logic [7:0] memSync1;
      logic [7:0] memSync2;
      logic [7:0] colData;
      logic colLatch;
      logic frameMark;
      logic rowDisN;
      logic oscEn;
   } lcdft_top_s;

endpackage

`default_nettype wire

// ==== lcdft_raster.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lcdft_defs.svh"

module lcdft_raster
   import lcdft_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Control
   input wire logic run,
   input wire logic [7:0] bytesPerLine,
   input wire logic [7:0] lineLength,
   input wire logic [7:0] linesPerFrame,
   input wire logic [15:0] pitch,
   // Raster position
   output logic [7:0] bytePos,
   output logic inDisplay,
   output logic [15:0] rasAddr,
   output logic lineStart,
   output logic frameStart
);

   lcdft_ras_s st_ff;
   lcdft_ras_s nxt_st;

   localparam lcdft_ras_s RAS_RST = '{default: '0, inDisp: 1'b1};

   always_comb begin
      nxt_st = st_ff;
      nxt_st.lineStart = 1'b0;
      nxt_st.frameStart = 1'b0;
      // Stopped oscillator: counters and address freeze in place; line and frame strobes clear
      if (run) begin
         if (st_ff.div == `LCDFT_BYTE_DIV - 4'h1) begin
            nxt_st.div = 4'h0;
            if (st_ff.pos == lineLength) begin
               nxt_st.pos = 8'h00;
               nxt_st.lineStart = 1'b1;
               if (st_ff.line == linesPerFrame) begin
                  nxt_st.line = 8'h00;
                  nxt_st.lineBase = 16'h0000;
                  nxt_st.frameStart = 1'b1;
               end else begin
                  nxt_st.line = st_ff.line + 8'h01;
                  nxt_st.lineBase = st_ff.lineBase + pitch;
               end
               nxt_st.addr = nxt_st.lineBase;
            end else begin
               nxt_st.pos = st_ff.pos + 8'h01;
               nxt_st.addr = st_ff.addr + 16'h0001;
            end
            nxt_st.inDisp = (nxt_st.pos <= bytesPerLine);
         end else begin
            nxt_st.div = st_ff.div + 4'h1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st_ff <= RAS_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign bytePos = st_ff.pos;
   assign inDisplay = st_ff.inDisp;
   assign rasAddr = st_ff.addr;
   assign lineStart = st_ff.lineStart;
   assign frameStart = st_ff.frameStart;

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   chk_line_wrap: assert property (lineStart |-> $past(st_ff.pos) == $past(lineLength))
      else $error("line ended at wrong byte position");
   chk_frame_wrap: assert property (frameStart |-> $past(st_ff.line) == $past(linesPerFrame))
      else $error("frame ended at wrong line");
   chk_pitch_step: assert property ((lineStart && !frameStart) |-> st_ff.lineBase == 16'($past(st_ff.lineBase) + $past(pitch)))
      else $error("line base did not advance by pitch");

endmodule // lcdft_raster

`default_nettype wire

// ==== lcdft_frame_timing.sv ====
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lcdft_defs.svh"

// Summary of operation
// - Bytes-per-line setting 0..239 shows setting plus one bytes per line.
// - Bytes per line within pitch; positions past it are blanked.
// - Line length setting 0..255 gives setting plus one byte periods.
// - Lines-per-frame setting 0..255 gives setting plus one lines.
// - Pitch is sixteen bits, low byte then high byte, per-line increment.
// - Sleep command has no parameters; later parameter bytes are ignored.
// - After sleep command, at least one blank frame, then halt oscillator.
// - On sleep entry, blank column data and disable row drivers.
// - Row disable goes low one to two frames after sleep command.
// - Configuration registers stay unchanged through sleep.
// - Memory control outputs hold their levels during sleep.
// - System-configuration command plus first parameter byte wakes the device.
// - Bus lines go high impedance while asleep.
// - Panel select bit: clear single panel, set dual panel.

module lcdft_frame_timing
   import lcdft_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   output logic hostBusOe,
   // Display memory
   output logic [15:0] memAddr,
   output logic memRdN,
   input wire logic [7:0] memDataIn,
   // Panel drivers
   output logic [7:0] colData,
   output logic colLatch,
   output logic frameMark,
   output logic rowDriverDisableN,
   // Power
   output logic oscEnable
);

   lcdft_top_s st_ff;
   lcdft_top_s nxt_st;

   localparam lcdft_top_s TOP_RST = '{
      mode: ST_RUN,
      cfgByte: `LCDFT_RST_CONFIG,
      bpl: `LCDFT_RST_BPL,
      llen: `LCDFT_RST_LLEN,
      lpf: `LCDFT_RST_LPF,
      pitch: `LCDFT_RST_PITCH,
      pidx: `LCDFT_PIDX_NONE,
      rdData: 8'h00,
      busOe: 1'b0,
      memAddr: 16'h0000,
      memRdN: 1'b1,
      memSync1: 8'h00,
      memSync2: 8'h00,
      colData: 8'h00,
      colLatch: 1'b0,
      frameMark: 1'b0,
      rowDisN: 1'b1,
      oscEn: 1'b1
   };

   logic [7:0] rasPos;
   logic rasInDisp;
   logic [15:0] rasAddr;
   logic rasLineStart;
   logic rasFrameStart;
   logic cmdWr;
   logic paramWr;
   logic dualPanel;
   logic parityBad;
   logic wakeNow;

   assign cmdWr = regWr && (regAddr == `LCDFT_ADDR_CMD);
   assign paramWr = regWr && (regAddr == `LCDFT_ADDR_PARAM);
   assign dualPanel = st_ff.cfgByte[`LCDFT_PANEL_BIT];
   // Flag an even setting in dual mode for software to see
   assign parityBad = dualPanel && !st_ff.lpf[0];
   assign wakeNow = (st_ff.mode == ST_SLEEP) && paramWr && (st_ff.pidx == `LCDFT_PIDX_CONFIG);

   // ST_RUN and ST_SLEEP both open parameters on this code, so one compare serves both
   function automatic logic isSysset(input logic [7:0] code);
      return code == `LCDFT_CMD_SYSSET;
   endfunction

   // Raster keeps running through the blank frame; only sleep stops it
   // Blanking length relies on the host keeping line length above the window
   lcdft_raster u_raster (
      .clock(clock),
      .rst_n(rst_n),
      .run(st_ff.mode != ST_SLEEP),
      .bytesPerLine(st_ff.bpl),
      .lineLength(st_ff.llen),
      .linesPerFrame(st_ff.lpf),
      .pitch(st_ff.pitch),
      .bytePos(rasPos),
      .inDisplay(rasInDisp),
      .rasAddr(rasAddr),
      .lineStart(rasLineStart),
      .frameStart(rasFrameStart)
   );

   always_comb begin
      nxt_st = st_ff;
      nxt_st.busOe = 1'b0;
      nxt_st.rdData = 8'h00;
      nxt_st.memSync1 = memDataIn;
      nxt_st.memSync2 = st_ff.memSync1;

      // Command byte decode
      if (cmdWr) begin
         unique case (st_ff.mode)
            ST_RUN: begin
               if (isSysset(regWrData)) begin
                  nxt_st.pidx = `LCDFT_PIDX_CONFIG;
               end else if (regWrData == `LCDFT_CMD_SLEEP) begin
                  nxt_st.pidx = `LCDFT_PIDX_NONE;
                  nxt_st.mode = ST_DRAIN;
               end else begin
                  nxt_st.pidx = `LCDFT_PIDX_NONE;
               end
            end
            ST_SLEEP: begin
               // Only the system-configuration command is heard while asleep
               if (isSysset(regWrData)) begin
                  nxt_st.pidx = `LCDFT_PIDX_CONFIG;
               end else begin
                  nxt_st.pidx = `LCDFT_PIDX_NONE;
               end
            end
            ST_DRAIN, ST_BLANKFRAME: begin
               nxt_st.pidx = `LCDFT_PIDX_NONE;
            end
         endcase
      end

      // Parameter bytes, ignored unless a command is expecting them
      if (paramWr && (st_ff.pidx != `LCDFT_PIDX_NONE)) begin
         nxt_st.pidx = st_ff.pidx + 4'd1;
         unique case (st_ff.pidx)
            `LCDFT_PIDX_CONFIG: nxt_st.cfgByte = regWrData;
            // Clamp to the largest legal setting
            `LCDFT_PIDX_BPL: begin
               // Values above the legal range cannot reach the raster
               if (regWrData > `LCDFT_BPL_MAX) begin
                  nxt_st.bpl = `LCDFT_BPL_MAX;
               end else begin
                  nxt_st.bpl = regWrData;
               end
            end
            `LCDFT_PIDX_LLEN: nxt_st.llen = regWrData;
            `LCDFT_PIDX_LPF: nxt_st.lpf = regWrData;
            // Pitch low byte first, then high byte
            `LCDFT_PIDX_PITCHL: nxt_st.pitch[7:0] = regWrData;
            `LCDFT_PIDX_PITCHH: begin
               nxt_st.pitch[15:8] = regWrData;
               nxt_st.pidx = `LCDFT_PIDX_NONE;
            end
            default: begin
               // Character-size bytes are accepted and dropped
            end
         endcase
         // First parameter byte alone wakes the device
         if (wakeNow) begin
            nxt_st.pidx = `LCDFT_PIDX_NONE;
            nxt_st.mode = ST_RUN;
            nxt_st.oscEn = 1'b1;
            nxt_st.rowDisN = 1'b1;
         end
      end

      // One full blank frame before halting
      if (rasFrameStart) begin
         if (st_ff.mode == ST_DRAIN) begin
            nxt_st.mode = ST_BLANKFRAME;
         end else if (st_ff.mode == ST_BLANKFRAME) begin
            // Second frame boundary after the command
            nxt_st.mode = ST_SLEEP;
            nxt_st.rowDisN = 1'b0;
            nxt_st.oscEn = 1'b0;
         end
      end

      if (st_ff.mode != ST_SLEEP) begin
         nxt_st.memAddr = rasAddr;
         nxt_st.memRdN = !rasInDisp;
      end

      // Blank column data from the sleep command onward
      if ((st_ff.mode == ST_RUN) && rasInDisp) begin
         nxt_st.colData = st_ff.memSync2;
      end else begin
         nxt_st.colData = 8'h00;
      end
      nxt_st.colLatch = rasLineStart;
      nxt_st.frameMark = rasFrameStart;

      // No read answer is driven while asleep
      if (regRd && (st_ff.mode != ST_SLEEP)) begin
         nxt_st.busOe = 1'b1;
         unique case (regAddr)
            `LCDFT_ADDR_BPL: nxt_st.rdData = st_ff.bpl;
            `LCDFT_ADDR_LLEN: nxt_st.rdData = st_ff.llen;
            `LCDFT_ADDR_LPF: nxt_st.rdData = st_ff.lpf;
            `LCDFT_ADDR_PITCHL: nxt_st.rdData = st_ff.pitch[7:0];
            `LCDFT_ADDR_PITCHH: nxt_st.rdData = st_ff.pitch[15:8];
            `LCDFT_ADDR_CONFIG: nxt_st.rdData = st_ff.cfgByte;
            `LCDFT_ADDR_STATUS: begin
               nxt_st.rdData = {parityBad, dualPanel, st_ff.rowDisN, st_ff.oscEn,
                                st_ff.mode};
            end
            default: nxt_st.rdData = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st_ff <= TOP_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Memory data arrives from pins, so colData lags the address by the synchroniser
   assign regRdData = st_ff.rdData;
   assign hostBusOe = st_ff.busOe;
   assign memAddr = st_ff.memAddr;
   assign memRdN = st_ff.memRdN;
   assign colData = st_ff.colData;
   assign colLatch = st_ff.colLatch;
   assign frameMark = st_ff.frameMark;
   assign rowDriverDisableN = st_ff.rowDisN;
   assign oscEnable = st_ff.oscEn;

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   chk_bpl_range: assert property (st_ff.bpl <= `LCDFT_BPL_MAX)
      else $error("bytes per line above legal range");
   chk_blank_excess: assert property ((colData != 8'h00) |-> $past(rasInDisp))
      else $error("data shown outside display window");
   chk_pitch_order: assert property ((paramWr && st_ff.pidx == `LCDFT_PIDX_PITCHH) |=> st_ff.pitch[15:8] == $past(regWrData))
      else $error("pitch high byte not stored");
   chk_sleep_noparam: assert property ((cmdWr && st_ff.mode == ST_RUN && regWrData == `LCDFT_CMD_SLEEP) |=> st_ff.pidx == `LCDFT_PIDX_NONE)
      else $error("sleep command left parameters open");
   chk_osc_halt: assert property ((st_ff.mode == ST_SLEEP) |-> !oscEnable)
      else $error("oscillator running in sleep");
   chk_blank_sleep: assert property ((st_ff.mode != ST_RUN) |=> colData == 8'h00)
      else $error("column data not blank on sleep entry");
   chk_rowdis_edge: assert property ($fell(rowDriverDisableN) |-> $past(st_ff.mode) == ST_BLANKFRAME && $past(rasFrameStart))
      else $error("row disable fell at wrong moment");
   chk_config_hold: assert property ((st_ff.mode == ST_SLEEP && !wakeNow) |=> $stable(st_ff.bpl) && $stable(st_ff.llen) && $stable(st_ff.lpf) && $stable(st_ff.pitch))
      else $error("configuration changed in sleep");
   chk_mem_hold: assert property ((st_ff.mode == ST_SLEEP) |=> $stable(memAddr) && $stable(memRdN))
      else $error("memory controls moved in sleep");
   chk_wake_p1: assert property (wakeNow |=> st_ff.mode == ST_RUN && oscEnable && rowDriverDisableN)
      else $error("first parameter byte did not wake");
   chk_bus_hiz: assert property (hostBusOe |-> $past(st_ff.mode) != ST_SLEEP)
      else $error("bus driven while asleep");

   // Out-of-range settings are clamped rather than refused, so the raster never overruns
   chk_bpl_clamp: assert property (
      (paramWr && st_ff.pidx == `LCDFT_PIDX_BPL && regWrData > `LCDFT_BPL_MAX)
      |=> st_ff.bpl == `LCDFT_BPL_MAX)
      else $error("bytes per line not clamped");
   chk_mark_latch: assert property (
      frameMark
      |-> colLatch)
      else $error("frame mark without line latch");
   chk_read_window: assert property (
      (!$past(regRd))
      |-> (!hostBusOe && regRdData == 8'h00))
      else $error("read data outside its cycle");
   chk_drain_ignore: assert property (
      ((st_ff.mode == ST_DRAIN || st_ff.mode == ST_BLANKFRAME) && regWr)
      |=> ($stable(st_ff.cfgByte) && $stable(st_ff.bpl) && st_ff.pidx == `LCDFT_PIDX_NONE))
      else $error("write heard while draining");
   chk_awake_drive: assert property (
      (st_ff.mode != ST_SLEEP)
      |-> (oscEnable && rowDriverDisableN))
      else $error("oscillator or row drivers off while awake");
   chk_data_pipe: assert property (
      ($past(st_ff.mode) == ST_RUN && $past(rasInDisp))
      |-> colData == $past(st_ff.memSync2))
      else $error("column data not from synchronised memory");

   cov_sleep_entry: cover property (st_ff.mode == ST_BLANKFRAME ##1 st_ff.mode == ST_SLEEP);
   cov_wake: cover property (wakeNow);
   cov_frame: cover property (frameMark);
   cov_read_status: cover property (regRd && regAddr == `LCDFT_ADDR_STATUS ##1 hostBusOe);
   cov_drain_param: cover property (st_ff.mode == ST_DRAIN && paramWr);

endmodule // lcdft_frame_timing

`default_nettype wire

// ==== lcdft_panel_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module lcdft_panel_model
   import lcdft_pkg::*;
(
   // Clock
   input wire logic clock,
   // Display memory side
   input wire logic [15:0] memAddr,
   input wire logic memRdN,
   output logic [7:0] memDataIn
);
   // One process owns the data pins, start value included
   initial begin
      memDataIn = 8'h5a;
      forever begin
         @(posedge clock);
         if (!memRdN) begin
            // Address-derived byte, so a wrong address shows in the data
            memDataIn <= memAddr[7:0] ^ memAddr[15:8];
         end else begin
            // Released bus toggles; a stale byte never looks valid
            memDataIn <= ~memDataIn;
         end
      end
   end
endmodule // lcdft_panel_model

`default_nettype wire

// ==== lcdft_frame_timing_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lcdft_defs.svh"

module lcdft_frame_timing_test
   import lcdft_pkg::*;
;
   logic clock, rst_n, regWr, regRd, hostBusOe, memRdN, colLatch, frameMark;
   logic rowDriverDisableN, oscEnable;
   logic [7:0] regAddr, regWrData, regRdData, memDataIn, colData, cfg, b;
   logic [15:0] memAddr, holdAddr;
   logic holdRd;
   int miscompares, cmpCount, cycles, n, frame;
   int regModel[9];
   logic [31:0] rng;

   lcdft_frame_timing lcdft_frame_timing_inst (.clock(clock), .rst_n(rst_n),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .hostBusOe(hostBusOe), .memAddr(memAddr), .memRdN(memRdN),
      .memDataIn(memDataIn), .colData(colData), .colLatch(colLatch),
      .frameMark(frameMark), .rowDriverDisableN(rowDriverDisableN),
      .oscEnable(oscEnable));

   lcdft_panel_model lcdft_panel_model_inst (.clock(clock), .memAddr(memAddr),
      .memRdN(memRdN), .memDataIn(memDataIn));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   function automatic logic [7:0] rnd8();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng[7:0];
   endfunction

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
      if (miscompares == 0 && cmpCount > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Ceiling well above the longest expected run
   always @(posedge clock) begin
      cycles++;
      if (cycles == 90000) begin
         miscompares++;
         stop_test();
      end
   end

   task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
      cmpCount++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clock);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clock);
      regWr <= 1'b0;
   endtask

   task automatic rd(logic [7:0] a, string name, logic [7:0] exp, logic expOe);
      @(posedge clock);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRd <= 1'b0;
      #1;
      chk(name, exp, regRdData);
      chk("hostBusOe", expOe, hostBusOe);
   endtask

   task automatic sysset(logic [7:0] c, logic [7:0] bp, logic [7:0] l, logic [7:0] f,
         logic [15:0] p);
      logic [7:0] pb[8];
      pb = '{c, rnd8(), rnd8(), bp, l, f, p[7:0], p[15:8]};
      wr(`LCDFT_ADDR_CMD, `LCDFT_CMD_SYSSET);
      foreach (pb[i]) wr(`LCDFT_ADDR_PARAM, pb[i]);
      regModel[7] = c;
      regModel[2] = (bp > 239) ? 239 : bp;
      regModel[3] = l;
      regModel[4] = f;
      regModel[5] = p[7:0];
      regModel[6] = p[15:8];
   endtask

   task automatic checkRegs();
      for (int i = 2; i < 8; i++) rd(8'(i * 4), "register", 8'(regModel[i]), 1'b1);
   endtask

   task automatic runFrame();
      int k, line, lines, lows;
      logic prevRd;
      logic [7:0] dq[$];
      frame = (regModel[3] + 1) * 4 * (regModel[4] + 1);
      k = 0;
      @(posedge clock);
      #1;
      while (frameMark !== 1'b1 && k < 30000) begin
         @(posedge clock);
         #1;
         k++;
      end
      line = 0;
      lines = 1;
      lows = (memRdN === 1'b0);
      prevRd = memRdN;
      dq.push_back(memDataIn);
      for (k = 1; k <= frame; k++) begin
         @(posedge clock);
         #1;
         if (k < frame && colLatch === 1'b1) begin
            line++;
            lines++;
         end
         if (k < frame && memRdN === 1'b0) lows++;
         if (prevRd === 1'b1 && memRdN === 1'b0) begin
            // The last pass lands on the next frame, whose base is zero
            chk("lineBase", 16'((k < frame ? line : 0) * (regModel[5] + 256 * regModel[6])),
               memAddr);
         end
         prevRd = memRdN;
         // Memory byte returns one clock later, then two sync stages and the output register
         dq.push_back(memDataIn);
         if (dq.size() > 4) void'(dq.pop_front());
         if (dq.size() == 4) chk("colData", (memRdN === 1'b0) ? dq[0] : 8'h00, colData);
      end
      chk("frameMark", 1'b1, frameMark);
      chk("linesPerFrame", 16'(regModel[4] + 1), 16'(lines));
      chk("dispCycles", 16'((regModel[2] + 1) * 4 * (regModel[4] + 1)), 16'(lows));
   endtask

   initial begin
      rng = 32'd31968;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 8'h00;
      regWrData = 8'h00;
      rst_n = 1'b0;
      regModel = '{0, 0, 'h27, 'h2f, 'h3f, 'h28, 0, 0, 0};
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      checkRegs();
      rd(`LCDFT_ADDR_STATUS, "status", 8'h31, 1'b1);
      rd(8'h24, "unmapped", 8'h00, 1'b1);
      runFrame();
      $display("done: reset and default raster");
      // Dual panel with even lines-per-frame setting, bytes per line past the top
      sysset(8'h08, 8'hf5, 8'hff, 8'h02, 16'h1234);
      checkRegs();
      rd(`LCDFT_ADDR_STATUS, "status", 8'hf1, 1'b1);
      b = rnd8() % 8 + 2;
      cfg = rnd8() | 8'h08;
      // Pitch exceeds the window by at most eight bytes of blank pixels
      sysset(cfg, b, b + 4 + rnd8() % 4, (rnd8() % 3) * 2 + 1,
         16'(b) + 16'(rnd8() % 9) + 16'h0001);
      wr(`LCDFT_ADDR_PARAM, rnd8());
      checkRegs();
      rd(`LCDFT_ADDR_STATUS, "status", 8'h71, 1'b1);
      runFrame();
      $display("done: programmed raster");
      wr(`LCDFT_ADDR_CMD, `LCDFT_CMD_SLEEP);
      wr(`LCDFT_ADDR_PARAM, rnd8());
      n = 2;
      while (rowDriverDisableN !== 1'b0 && n < 3 * frame) begin
         @(posedge clock);
         #1;
         n++;
         chk("colData", 8'h00, colData);
      end
      chk("rowDisableDelay", 1'b1, n >= frame && n <= 2 * frame + 2);
      chk("oscEnable", 1'b0, oscEnable);
      holdAddr = memAddr;
      holdRd = memRdN;
      repeat (40) @(posedge clock);
      #1;
      chk("memAddr", holdAddr, memAddr);
      chk("memRdN", holdRd, memRdN);
      chk("colData", 8'h00, colData);
      rd(`LCDFT_ADDR_BPL, "sleepRead", 8'h00, 1'b0);
      $display("done: sleep entry");
      cfg = rnd8() & 8'hf7;
      wr(`LCDFT_ADDR_CMD, `LCDFT_CMD_SYSSET);
      wr(`LCDFT_ADDR_PARAM, cfg);
      @(posedge clock);
      #1;
      chk("oscEnable", 1'b1, oscEnable);
      chk("rowDisable", 1'b1, rowDriverDisableN);
      wr(`LCDFT_ADDR_CMD, `LCDFT_CMD_DISPLAY_EN);
      wr(`LCDFT_ADDR_PARAM, rnd8());
      regModel[7] = cfg;
      checkRegs();
      rd(`LCDFT_ADDR_STATUS, "status", 8'h31, 1'b1);
      runFrame();
      $display("done: wake");
      stop_test();
   end
endmodule // lcdft_frame_timing_test

`default_nettype wire
